/* hw/interrupt_flag_status_bank0.sv */
// Interrupt flag status bank 0: sticky per-source flags with register port and interrupt output.
// Operation
// - flag reads one after request, else zero
// - bit 10 is first SPI event flag
// - bit 8 is third timer flag
// - bit 5 is second capture flag
// - bit 2 is first compare flag
// - bit 1 is first capture flag
// - bit 0 is external interrupt zero flag
`timescale 1ns/100ps
module interrupt_flag_status_bank0 (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Source events, one-cycle pulses on clk_sys
  input wire ifs_pkg::src_evt_type src_evt,
  // Register port
  input wire ifs_pkg::reg_req_type reg_req,
  output logic [15:0] reg_rdata,
  // Interrupt
  output logic irq
);
  import ifs_pkg::*;

  // ---------------------------------------------------------------
  // Flag state
  // ---------------------------------------------------------------
  logic [15:0] evt_vec;
  logic [15:0] interrupt_flag_status_0_ff;
  logic [15:0] nxt_interrupt_flag_status_0;
  logic [15:0] enable_ff;
  logic [15:0] nxt_enable;
  logic [15:0] rdata_ff;
  logic [15:0] nxt_rdata;
  logic irq_ff;
  logic nxt_irq;

  flag_map u_map (
    .evt(src_evt),
    .vec(evt_vec)
  );

  function automatic logic hit(input reg_req_type r, input logic [3:0] a, input logic w);
    hit = (r.addr == a) && (w ? r.wr : r.rd);
  endfunction

  // Software writes land first, then new events are ORed on so that an
  // event in the same cycle as a clear or write of zero is never lost.
  always_comb begin
    nxt_interrupt_flag_status_0 = interrupt_flag_status_0_ff;
    if (hit(reg_req, ADDR_FLAGS, 1'b1)) begin
      nxt_interrupt_flag_status_0 = reg_req.wdata;
    end else if (hit(reg_req, ADDR_CLEAR, 1'b1)) begin
      nxt_interrupt_flag_status_0 = interrupt_flag_status_0_ff & ~reg_req.wdata;
    end
    nxt_interrupt_flag_status_0 = (nxt_interrupt_flag_status_0 | evt_vec) & IMPL_MASK;
    nxt_enable = enable_ff;
    if (hit(reg_req, ADDR_ENABLE, 1'b1)) begin
      nxt_enable = reg_req.wdata & IMPL_MASK;
    end
    nxt_irq = |(nxt_interrupt_flag_status_0 & nxt_enable);
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  always_comb begin
    nxt_rdata = 16'h0000;
    if (reg_req.rd) begin
      case (reg_req.addr)
        ADDR_FLAGS: nxt_rdata = interrupt_flag_status_0_ff;
        ADDR_ENABLE: nxt_rdata = enable_ff;
        ADDR_LATCHED: nxt_rdata = interrupt_flag_status_0_ff & enable_ff;
        default: nxt_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      interrupt_flag_status_0_ff <= FLAGS_RESET;
      enable_ff <= ENABLE_RESET;
      rdata_ff <= 16'h0000;
      irq_ff <= 1'b0;
    end else begin
      interrupt_flag_status_0_ff <= nxt_interrupt_flag_status_0;
      enable_ff <= nxt_enable;
      rdata_ff <= nxt_rdata;
      irq_ff <= nxt_irq;
    end
  end

  assign reg_rdata = rdata_ff;
  assign irq = irq_ff;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence s_flag_read;
    reg_req.rd && reg_req.addr == ADDR_FLAGS;
  endsequence

  property p_evt_sets;
    @(posedge clk_sys) disable iff (!rst_b) (|(evt_vec & IMPL_MASK)) |=> ((interrupt_flag_status_0_ff & $past(evt_vec & IMPL_MASK)) == $past(evt_vec & IMPL_MASK));
  endproperty
  a_evt_sets: assert property (p_evt_sets) else $error("event did not set flag");

  property p_no_spurious;
    @(posedge clk_sys) disable iff (!rst_b) (evt_vec == 16'h0000 && !reg_req.wr) |=> interrupt_flag_status_0_ff == $past(interrupt_flag_status_0_ff);
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("flag changed without cause");

  property p_spi_event_bit;
    @(posedge clk_sys) disable iff (!rst_b) src_evt.spi_first_event_flag |=> interrupt_flag_status_0_ff[10];
  endproperty
  a_spi_event_bit: assert property (p_spi_event_bit) else $error("spi event not at bit 10");

  property p_timer3_bit;
    @(posedge clk_sys) disable iff (!rst_b) src_evt.timer_third_flag |=> interrupt_flag_status_0_ff[8];
  endproperty
  a_timer3_bit: assert property (p_timer3_bit) else $error("timer3 not at bit 8");

  property p_cap2_bit;
    @(posedge clk_sys) disable iff (!rst_b) src_evt.capture_ch2_flag |=> interrupt_flag_status_0_ff[5];
  endproperty
  a_cap2_bit: assert property (p_cap2_bit) else $error("capture2 not at bit 5");

  property p_bit15_zero;
    @(posedge clk_sys) disable iff (!rst_b) s_flag_read |=> reg_rdata[15] == 1'b0;
  endproperty
  a_bit15_zero: assert property (p_bit15_zero) else $error("bit 15 read nonzero");

  property p_cmp1_bit;
    @(posedge clk_sys) disable iff (!rst_b) src_evt.compare_ch1_flag ##1 !reg_req.wr ##1 s_flag_read |=> reg_rdata[2];
  endproperty
  a_cmp1_bit: assert property (p_cmp1_bit) else $error("compare1 not at bit 2");

  property p_cap1_bit;
    @(posedge clk_sys) disable iff (!rst_b) src_evt.capture_ch1_flag |=> interrupt_flag_status_0_ff[1];
  endproperty
  a_cap1_bit: assert property (p_cap1_bit) else $error("capture1 not at bit 1");

  property p_ext0_bit;
    @(posedge clk_sys) disable iff (!rst_b) src_evt.ext_irq_zero_flag |=> interrupt_flag_status_0_ff[0];
  endproperty
  a_ext0_bit: assert property (p_ext0_bit) else $error("ext irq 0 not at bit 0");

  property p_dma1_bit;
    @(posedge clk_sys) disable iff (!rst_b) src_evt.dma_ch1_done_flag |=> interrupt_flag_status_0_ff[14];
  endproperty
  a_dma1_bit: assert property (p_dma1_bit) else $error("dma1 done not at bit 14");

  property p_adc_bit;
    @(posedge clk_sys) disable iff (!rst_b) src_evt.adc_first_done_flag |=> interrupt_flag_status_0_ff[13];
  endproperty
  a_adc_bit: assert property (p_adc_bit) else $error("adc done not at bit 13");

  property p_utx_bit;
    @(posedge clk_sys) disable iff (!rst_b) src_evt.uart_first_tx_flag |=> interrupt_flag_status_0_ff[12];
  endproperty
  a_utx_bit: assert property (p_utx_bit) else $error("uart tx not at bit 12");

  property p_urx_bit;
    @(posedge clk_sys) disable iff (!rst_b) src_evt.uart_first_rx_flag |=> interrupt_flag_status_0_ff[11];
  endproperty
  a_urx_bit: assert property (p_urx_bit) else $error("uart rx not at bit 11");

  property p_spi_err_bit;
    @(posedge clk_sys) disable iff (!rst_b) src_evt.spi_first_error_flag |=> interrupt_flag_status_0_ff[9];
  endproperty
  a_spi_err_bit: assert property (p_spi_err_bit) else $error("spi error not at bit 9");

  property p_timer2_bit;
    @(posedge clk_sys) disable iff (!rst_b) src_evt.timer_second_flag |=> interrupt_flag_status_0_ff[7];
  endproperty
  a_timer2_bit: assert property (p_timer2_bit) else $error("timer2 not at bit 7");

  property p_cmp2_bit;
    @(posedge clk_sys) disable iff (!rst_b) src_evt.compare_ch2_flag |=> interrupt_flag_status_0_ff[6];
  endproperty
  a_cmp2_bit: assert property (p_cmp2_bit) else $error("compare2 not at bit 6");

  property p_dma0_bit;
    @(posedge clk_sys) disable iff (!rst_b) src_evt.dma_ch0_done_flag |=> interrupt_flag_status_0_ff[4];
  endproperty
  a_dma0_bit: assert property (p_dma0_bit) else $error("dma0 done not at bit 4");

  property p_timer1_bit;
    @(posedge clk_sys) disable iff (!rst_b) src_evt.timer_first_flag |=> interrupt_flag_status_0_ff[3];
  endproperty
  a_timer1_bit: assert property (p_timer1_bit) else $error("timer1 not at bit 3");

  // ---------------------------------------------------------------
  // Register port and interrupt assertions
  // ---------------------------------------------------------------
  property p_read_flags;
    @(posedge clk_sys) disable iff (!rst_b) s_flag_read |=> reg_rdata == $past(interrupt_flag_status_0_ff);
  endproperty
  a_read_flags: assert property (p_read_flags) else $error("flag read returned wrong value");

  property p_read_idle_zero;
    @(posedge clk_sys) disable iff (!rst_b) !reg_req.rd |=> reg_rdata == 16'h0000;
  endproperty
  a_read_idle_zero: assert property (p_read_idle_zero) else $error("read data outside its cycle");

  property p_flag_write;
    @(posedge clk_sys) disable iff (!rst_b) (reg_req.wr && reg_req.addr == ADDR_FLAGS && evt_vec == 16'h0000) |=>
      interrupt_flag_status_0_ff == ($past(reg_req.wdata) & IMPL_MASK);
  endproperty
  a_flag_write: assert property (p_flag_write) else $error("flag write not stored");

  property p_clear_write;
    @(posedge clk_sys) disable iff (!rst_b) (reg_req.wr && reg_req.addr == ADDR_CLEAR && evt_vec == 16'h0000) |=>
      (interrupt_flag_status_0_ff & $past(reg_req.wdata)) == 16'h0000;
  endproperty
  a_clear_write: assert property (p_clear_write) else $error("clear left a flag set");

  property p_enable_write;
    @(posedge clk_sys) disable iff (!rst_b) (reg_req.wr && reg_req.addr == ADDR_ENABLE) |=> enable_ff == ($past(reg_req.wdata) & IMPL_MASK);
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable write not stored");

  // The output is registered from next-state values, so it tracks the stored flags with no lag.
  property p_irq_level;
    @(posedge clk_sys) disable iff (!rst_b) irq == |(interrupt_flag_status_0_ff & enable_ff);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq does not follow enabled flags");

endmodule

/* hw/ifs_pkg.sv */
// Package with register map, bit positions and reset values for the interrupt flag status bank.
package ifs_pkg;

  localparam int FLAG_W = 16;
  localparam logic [3:0] ADDR_FLAGS = 4'h0;
  localparam logic [3:0] ADDR_CLEAR = 4'h1;
  localparam logic [3:0] ADDR_ENABLE = 4'h2;
  localparam logic [3:0] ADDR_LATCHED = 4'h3;
  localparam logic [15:0] FLAGS_RESET = 16'h0000;
  localparam logic [15:0] ENABLE_RESET = 16'h0000;
  localparam logic [15:0] IMPL_MASK = 16'h7FFF;

  localparam int POS_EXT_IRQ_ZERO = 0;
  localparam int POS_CAPTURE_CH1 = 1;
  localparam int POS_COMPARE_CH1 = 2;
  localparam int POS_TIMER_FIRST = 3;
  localparam int POS_DMA_CH0_DONE = 4;
  localparam int POS_CAPTURE_CH2 = 5;
  localparam int POS_COMPARE_CH2 = 6;
  localparam int POS_TIMER_SECOND = 7;
  localparam int POS_TIMER_THIRD = 8;
  localparam int POS_SPI_FIRST_ERROR = 9;
  localparam int POS_SPI_FIRST_EVENT = 10;
  localparam int POS_UART_FIRST_RX = 11;
  localparam int POS_UART_FIRST_TX = 12;
  localparam int POS_ADC_FIRST_DONE = 13;
  localparam int POS_DMA_CH1_DONE = 14;

  // Event pulses, one per source.
  typedef struct packed {
    logic dma_ch1_done_flag;
    logic adc_first_done_flag;
    logic uart_first_tx_flag;
    logic uart_first_rx_flag;
    logic spi_first_event_flag;
    logic spi_first_error_flag;
    logic timer_third_flag;
    logic timer_second_flag;
    logic compare_ch2_flag;
    logic capture_ch2_flag;
    logic dma_ch0_done_flag;
    logic timer_first_flag;
    logic compare_ch1_flag;
    logic capture_ch1_flag;
    logic ext_irq_zero_flag;
  } src_evt_type;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_type;

endpackage

/* hw/flag_map.sv */
// Maps the source event struct onto the 16-bit flag layout.
`timescale 1ns/100ps
module flag_map (
  // Source events
  input wire ifs_pkg::src_evt_type evt,
  // Flag vector
  output logic [15:0] vec
);
  import ifs_pkg::*;

  always_comb begin
    vec = 16'h0000;
    vec[POS_DMA_CH1_DONE] = evt.dma_ch1_done_flag;
    vec[POS_ADC_FIRST_DONE] = evt.adc_first_done_flag;
    vec[POS_UART_FIRST_TX] = evt.uart_first_tx_flag;
    vec[POS_UART_FIRST_RX] = evt.uart_first_rx_flag;
    vec[POS_SPI_FIRST_EVENT] = evt.spi_first_event_flag;
    vec[POS_SPI_FIRST_ERROR] = evt.spi_first_error_flag;
    vec[POS_TIMER_THIRD] = evt.timer_third_flag;
    vec[POS_TIMER_SECOND] = evt.timer_second_flag;
    vec[POS_COMPARE_CH2] = evt.compare_ch2_flag;
    vec[POS_CAPTURE_CH2] = evt.capture_ch2_flag;
    vec[POS_DMA_CH0_DONE] = evt.dma_ch0_done_flag;
    vec[POS_TIMER_FIRST] = evt.timer_first_flag;
    vec[POS_COMPARE_CH1] = evt.compare_ch1_flag;
    vec[POS_CAPTURE_CH1] = evt.capture_ch1_flag;
    vec[POS_EXT_IRQ_ZERO] = evt.ext_irq_zero_flag;
  end

endmodule

/* tb/interrupt_flag_status_bank0_bench.sv */
// Self-checking bench for the interrupt flag status bank.
`timescale 1ns/100ps
module interrupt_flag_status_bank0_bench;
  import ifs_pkg::*;
  // ------------------------------------------------------------
  // Stimulus and design
  // ------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  src_evt_type src_evt = '0;
  reg_req_type reg_req = '0;
  logic [15:0] reg_rdata;
  logic irq;
  int fails = 0;
  int total_checks = 0;
  int cycles = 0;
  always #4 clk_sys = ~clk_sys;
  interrupt_flag_status_bank0 i_dut (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .src_evt(src_evt),
    .reg_req(reg_req),
    .reg_rdata(reg_rdata),
    .irq(irq)
  );
  // ------------------------------------------------------------
  // Access tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    reg_req <= '0;
  endtask
  // Read data is valid only in the cycle after the strobe, so it is sampled just past that edge.
  task automatic rd(input logic [3:0] a, input logic [15:0] exp, input string what);
    @(posedge clk_sys);
    reg_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    reg_req <= '0;
    #1;
    chk(reg_rdata, exp, what);
  endtask
  task automatic pulse(input logic [14:0] bits);
    @(posedge clk_sys);
    src_evt <= src_evt_type'(bits);
    @(posedge clk_sys);
    src_evt <= '0;
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      $display("unexpected at %0t: timeout", $time);
      summarize();
    end
  end
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    rd(ADDR_FLAGS, 16'h0000, "flags reset");
    rd(ADDR_ENABLE, 16'h0000, "enable reset");
    chk({15'h0000, irq}, 16'h0000, "irq reset");
    $display("test reset done");
    // Each source sets exactly its own bit; clearing restores zero.
    for (int i = 0; i < 15; i++) begin
      pulse(15'(1 << i));
      rd(ADDR_FLAGS, 16'(1 << i), "source bit");
      wr(ADDR_CLEAR, 16'hFFFF);
      rd(ADDR_FLAGS, 16'h0000, "after clear");
    end
    $display("test source map done");
    wr(ADDR_FLAGS, 16'hFFFF);
    rd(ADDR_FLAGS, 16'h7FFF, "write all ones");
    wr(ADDR_FLAGS, 16'h0000);
    rd(ADDR_FLAGS, 16'h0000, "write zeros");
    $display("test read write done");
    wr(ADDR_ENABLE, 16'h0100);
    rd(ADDR_ENABLE, 16'h0100, "enable readback");
    pulse(15'h0020);
    rd(ADDR_LATCHED, 16'h0000, "masked source");
    chk({15'h0000, irq}, 16'h0000, "irq masked");
    pulse(15'h0100);
    rd(ADDR_LATCHED, 16'h0100, "enabled source");
    chk({15'h0000, irq}, 16'h0001, "irq raised");
    wr(ADDR_CLEAR, 16'h0100);
    rd(ADDR_FLAGS, 16'h0020, "partial clear");
    chk({15'h0000, irq}, 16'h0000, "irq dropped");
    $display("test interrupt done");
    wr(4'h9, 16'hFFFF);
    rd(4'h9, 16'h0000, "unmapped read");
    rd(ADDR_FLAGS, 16'h0020, "unmapped write ignored");
    rd(ADDR_CLEAR, 16'h0000, "clear reads zero");
    $display("test unmapped done");
    @(posedge clk_sys);
    src_evt <= src_evt_type'(15'h0400);
    reg_req <= '{addr: ADDR_CLEAR, wdata: 16'hFFFF, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    src_evt <= '0;
    reg_req <= '0;
    rd(ADDR_FLAGS, 16'h0400, "event beats clear");
    $display("test collision done");
    wr(ADDR_ENABLE, 16'h0400);
    rd(ADDR_LATCHED, 16'h0400, "latched before reset");
    chk({15'h0000, irq}, 16'h0001, "irq before reset");
    @(posedge clk_sys);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    rd(ADDR_FLAGS, 16'h0000, "flags after reset");
    rd(ADDR_ENABLE, 16'h0000, "enable after reset");
    chk({15'h0000, irq}, 16'h0000, "irq after reset");
    $display("test mid reset done");
    summarize();
  end
endmodule
